// ==== rtl/pieb_pkg.sv ====
/*
 * pieb_pkg: register map, field positions and reset values of the
 * peripheral interrupt enable bank.
 * assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package pieb_pkg;

    // source count and bus widths
    localparam int NUM_SRC  = 4;
    localparam int ADR_W    = 8;
    localparam int DAT_W    = 32;

    // byte addresses, one aligned word each
    localparam logic [7:0] ADR_CORE_IRQ_CONTROL  = 8'h80;
    localparam logic [7:0] ADR_IRQ_STATUS        = 8'h84;
    localparam logic [7:0] ADR_PERIPH_IRQ_ENABLE = 8'h8C;

    // peripheral_irq_enable fields
    localparam int TIMER_A_OVERFLOW_IRQ_ENABLE = 0;
    localparam int TIMER_B_MATCH_IRQ_ENABLE    = 1;
    localparam int CAPCMP_UNIT1_IRQ_ENABLE     = 2;
    localparam int SERIAL_PORT_IRQ_ENABLE      = 3;
    localparam int UNIMPL_LO                   = 4;
    localparam int UNIMPL_HI                   = 5;
    localparam logic [7:0] PIE_WRITE_MASK      = 8'hCF;
    localparam logic [7:0] PIE_RESET           = 8'h00;

    // core_irq_control fields
    localparam int PERIPH_IRQ_MASTER_ENABLE = 6;
    localparam int GLOBAL_IRQ_ENABLE        = 7;
    localparam logic [7:0] CTL_WRITE_MASK   = 8'hC0;
    localparam logic [7:0] CTL_RESET        = 8'h00;

    // status word layout
    localparam int STAT_FLAG_LSB = 0;
    localparam int STAT_REQ_LSB  = 8;

endpackage

// ==== rtl/pieb_req_gate.sv ====
/*
 * pieb_req_gate: registered request gate for one peripheral source.
 * assumes flag and enables come from logic on core_clk, reset already
 * synchronised by the top.
 */
`timescale 1ns/1ps
module pieb_req_gate
    import pieb_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_sync_n,
    // gate terms
    input  wire logic src_flag,
    input  wire logic src_enable,
    input  wire logic periph_en,
    input  wire logic global_en,
    // request toward the core
    output logic      irq_req_q
);

    logic irq_req_d;

    assign irq_req_d = src_flag & src_enable & periph_en & global_en;

    // registered so the core never sees a glitch from the and-gate
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            irq_req_q <= 1'b0;
        end
        else
        begin
            irq_req_q <= irq_req_d;
        end
    end

    blocked_src_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        !src_enable |=> !irq_req_q)
        else $error("request raised while source enable was low");

    and_form_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        (src_flag && src_enable && periph_en && global_en) |=> irq_req_q)
        else $error("all gate terms high but no request followed");

endmodule

// ==== rtl/pieb_top.sv ====
/*
 * pieb_top: peripheral interrupt enable bank with a classic Wishbone
 * slave, one enable per source and a registered request per source.
 * assumes source flags and bus signals are synchronous to core_clk;
 * only rst_n comes from outside and is synchronised here.
 */
`timescale 1ns/1ps
module pieb_top
    import pieb_pkg::*;
(
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [DAT_W-1:0]   wb_dat_i,
    output logic      [DAT_W-1:0]   wb_dat_o,
    output logic                    wb_ack_o,
    // peripheral flags in, requests out
    input  wire logic [NUM_SRC-1:0] src_flag,
    output logic      [NUM_SRC-1:0] irq_req
);

    logic               rst_meta_q;
    logic               rst_sync_q;
    logic [7:0]         pie_q;
    logic [7:0]         ctl_q;
    logic               ack_q;
    logic [DAT_W-1:0]   rdat_q;
    logic [DAT_W-1:0]   rdat_d;
    logic               req_new;
    logic               wr_lo;
    logic               hit_pie;
    logic               hit_ctl;
    logic               hit_stat;
    logic [NUM_SRC-1:0] req_q;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // address decode on word index, low two address bits ignored
    assign hit_pie  = (wb_adr_i[ADR_W-1:2] == ADR_PERIPH_IRQ_ENABLE[ADR_W-1:2]);
    assign hit_ctl  = (wb_adr_i[ADR_W-1:2] == ADR_CORE_IRQ_CONTROL[ADR_W-1:2]);
    assign hit_stat = (wb_adr_i[ADR_W-1:2] == ADR_IRQ_STATUS[ADR_W-1:2]);

    // a request is taken once; ack high in the following cycle keeps it single
    assign req_new = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_lo   = req_new & wb_we_i & wb_sel_i[0];

    // bus handshake, answer one cycle after the request
    always_ff @(posedge core_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req_new;
        end
    end

    // enable register; bits 5:4 never stored
    always_ff @(posedge core_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            pie_q <= PIE_RESET;
        end
        else if (wr_lo && hit_pie)
        begin
            pie_q <= wb_dat_i[7:0] & PIE_WRITE_MASK;
        end
    end

    // core control: only global and peripheral master enables exist
    always_ff @(posedge core_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            ctl_q <= CTL_RESET;
        end
        else if (wr_lo && hit_ctl)
        begin
            ctl_q <= wb_dat_i[7:0] & CTL_WRITE_MASK;
        end
    end

    // read mux; unmapped words answer zero
    always_comb
    begin
        rdat_d = '0;
        if (hit_pie)
        begin
            rdat_d[7:0] = pie_q & PIE_WRITE_MASK;
        end
        else if (hit_ctl)
        begin
            rdat_d[7:0] = ctl_q;
        end
        else if (hit_stat)
        begin
            rdat_d[STAT_FLAG_LSB +: NUM_SRC] = src_flag;
            rdat_d[STAT_REQ_LSB +: NUM_SRC]  = req_q;
        end
    end

    // read data held until the next read request so it stands with ack
    always_ff @(posedge core_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            rdat_q <= '0;
        end
        else if (req_new && !wb_we_i)
        begin
            rdat_q <= rdat_d;
        end
    end

    // one gate per source; bit position in pie_q equals source index
    generate
        for (genvar i = 0; i < NUM_SRC; i++)
        begin : g_gate
            pieb_req_gate u_gate (
                .core_clk   (core_clk),
                .rst_sync_n (rst_sync_q),
                .src_flag   (src_flag[i]),
                .src_enable (pie_q[i]),
                .periph_en  (ctl_q[PERIPH_IRQ_MASTER_ENABLE]),
                .global_en  (ctl_q[GLOBAL_IRQ_ENABLE]),
                .irq_req_q  (req_q[i])
            );
        end
    endgenerate

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_req  = req_q;

    periph_mask_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        !ctl_q[PERIPH_IRQ_MASTER_ENABLE] |=> (irq_req == '0))
        else $error("request seen with peripheral master enable low");

    enable_write_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        (wr_lo && hit_pie) |=> (pie_q == ($past(wb_dat_i[7:0]) & PIE_WRITE_MASK)))
        else $error("enable register did not take the written value");

    unimpl_read_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        (req_new && !wb_we_i && hit_pie) |=> (wb_ack_o && wb_dat_o[UNIMPL_HI:UNIMPL_LO] == 2'h0))
        else $error("unimplemented enable bits did not read zero");

    unimpl_store_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        pie_q[UNIMPL_HI:UNIMPL_LO] == 2'h0)
        else $error("unimplemented enable bits were stored");

    serial_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        (pie_q[SERIAL_PORT_IRQ_ENABLE] && src_flag[SERIAL_PORT_IRQ_ENABLE]
         && ctl_q[PERIPH_IRQ_MASTER_ENABLE] && ctl_q[GLOBAL_IRQ_ENABLE])
        |=> irq_req[SERIAL_PORT_IRQ_ENABLE])
        else $error("serial port request not raised");

    capcmp_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        (pie_q[CAPCMP_UNIT1_IRQ_ENABLE] && src_flag[CAPCMP_UNIT1_IRQ_ENABLE]
         && ctl_q[PERIPH_IRQ_MASTER_ENABLE] && ctl_q[GLOBAL_IRQ_ENABLE])
        |=> irq_req[CAPCMP_UNIT1_IRQ_ENABLE])
        else $error("capture/compare request not raised");

    timer_b_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        (pie_q[TIMER_B_MATCH_IRQ_ENABLE] && src_flag[TIMER_B_MATCH_IRQ_ENABLE]
         && ctl_q[PERIPH_IRQ_MASTER_ENABLE] && ctl_q[GLOBAL_IRQ_ENABLE])
        |=> irq_req[TIMER_B_MATCH_IRQ_ENABLE])
        else $error("timer-b match request not raised");

    timer_a_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_sync_q)
        (pie_q[TIMER_A_OVERFLOW_IRQ_ENABLE] && src_flag[TIMER_A_OVERFLOW_IRQ_ENABLE]
         && ctl_q[PERIPH_IRQ_MASTER_ENABLE] && ctl_q[GLOBAL_IRQ_ENABLE])
        |=> irq_req[TIMER_A_OVERFLOW_IRQ_ENABLE])
        else $error("timer-a overflow request not raised");

    reset_clear_a: assert property (
        @(posedge core_clk)
        $rose(rst_sync_q) |-> (pie_q == PIE_RESET && irq_req == '0))
        else $error("enables not clear after reset release");

endmodule

// ==== verification/peripheral_irq_enable_bank_bench.sv ====
/*
 * peripheral_irq_enable_bank_bench: self-checking bench for pieb_top.
 * assumes the registered one-cycle ack and the one-cycle request lag of the design.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, g, e); end end
module peripheral_irq_enable_bank_bench
    import pieb_pkg::*;
;
    typedef struct packed
    {
        logic [7:0] en;
        logic [7:0] ctl;
        logic [3:0] flag;
        logic [3:0] req;
    } pieb_row_t;
    // clock, reset and bus
    logic                 core_clk = 1'b0;
    logic                 rst_n;
    logic                 wb_cyc_i = 1'b0;
    logic                 wb_stb_i = 1'b0;
    logic                 wb_we_i  = 1'b0;
    logic [ADR_W-1:0]     wb_adr_i = 8'h00;
    logic [3:0]           wb_sel_i = 4'h0;
    logic [DAT_W-1:0]     wb_dat_i = 32'h00000000;
    logic [DAT_W-1:0]     wb_dat_o;
    logic                 wb_ack_o;
    // sources
    logic [NUM_SRC-1:0]   src_flag = 4'h0;
    logic [NUM_SRC-1:0]   irq_req;
    // bench state
    logic                 ack_s    = 1'b0;
    logic [DAT_W-1:0]     dat_s    = 32'h00000000;
    logic [7:0]           rd;
    int                   err_count = 0;
    int                   cmp_count = 0;
    // enables, control, flags and the requests they should give
    pieb_row_t rows [9] = '{
        '{8'h0F, 8'hC0, 4'hF, 4'hF},
        '{8'h08, 8'hC0, 4'hF, 4'h8},
        '{8'h04, 8'hC0, 4'hF, 4'h4},
        '{8'h02, 8'hC0, 4'hF, 4'h2},
        '{8'h01, 8'hC0, 4'hF, 4'h1},
        '{8'h00, 8'hC0, 4'hF, 4'h0},
        '{8'h0F, 8'h80, 4'hF, 4'h0},
        '{8'h0F, 8'h40, 4'hF, 4'h0},
        '{8'h05, 8'hC0, 4'h6, 4'h4}
    };

    pieb_top dut_u (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .src_flag (src_flag),
        .irq_req  (irq_req)
    );

    always #50 core_clk = ~core_clk;

    // half-cycle copies give the value present at the next rising edge, free of races
    always @(negedge core_clk)
    begin
        ack_s <= wb_ack_o;
        dat_s <= wb_dat_o;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one classic cycle, entered just after a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [7:0] rdat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, wd};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (ack_s !== 1'b1);
        `CHK(n, 2)
        rdat = dat_s[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
        `CHK(ack_s, 1'b0)
    endtask

    initial
    begin
        #(5000 * 100);
        err_count++;
        end_sim();
    end

    initial
    begin
        // x to 0 at time zero fires the async resets before the first edge
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        wb(1'b0, ADR_PERIPH_IRQ_ENABLE, 8'h00, rd);
        `CHK(rd, PIE_RESET)
        `CHK(irq_req, 4'h0)
        foreach (rows[i])
        begin
            wb(1'b1, ADR_PERIPH_IRQ_ENABLE, rows[i].en, rd);
            wb(1'b1, ADR_CORE_IRQ_CONTROL, rows[i].ctl, rd);
            wb(1'b0, ADR_PERIPH_IRQ_ENABLE, 8'h00, rd);
            `CHK(rd, rows[i].en)
            src_flag <= rows[i].flag;
            @(negedge core_clk);
            `CHK(irq_req, 4'h0)
            @(negedge core_clk);
            `CHK(irq_req, rows[i].req)
            @(posedge core_clk);
            src_flag <= 4'h0;
            @(posedge core_clk);
        end
        // unimplemented bits 5:4 written high, must read back as zero
        wb(1'b1, ADR_PERIPH_IRQ_ENABLE, 8'h3F, rd);
        wb(1'b0, ADR_PERIPH_IRQ_ENABLE, 8'h00, rd);
        `CHK(rd, 8'h0F)
        wb(1'b0, 8'h90, 8'h00, rd);
        `CHK(rd, 8'h00)
        // reset in mid-run with every source requesting
        src_flag <= 4'hF;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(irq_req, 4'hF)
        @(posedge core_clk);
        wb(1'b0, ADR_IRQ_STATUS, 8'h00, rd);
        `CHK(dat_s, 32'h00000F0F)
        wb(1'b0, ADR_CORE_IRQ_CONTROL, 8'h00, rd);
        `CHK(rd, 8'hC0)
        rst_n <= 1'b0;
        @(negedge core_clk);
        `CHK(irq_req, 4'h0)
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        wb(1'b0, ADR_PERIPH_IRQ_ENABLE, 8'h00, rd);
        `CHK(rd, PIE_RESET)
        `CHK(irq_req, 4'h0)
        end_sim();
    end
endmodule
